//--- swch_defines.vh
// constants for the store write clock and handshake block
`ifndef SWCH_DEFINES_VH
`define SWCH_DEFINES_VH
`define SWCH_CLK_PERIOD_PS   25000
`define SWCH_SYNC_UNC_PS     250000
`define SWCH_SYNC_MAX_CYC    ((`SWCH_SYNC_UNC_PS) / (`SWCH_CLK_PERIOD_PS))
`define SWCH_SWEEP_SAMPLES   4000
`define SWCH_ADDR_W          12
`define SWCH_DIV_W           16
`define SWCH_DIV_RST         16'h0013
`define SWCH_ADDR_CTRL       12'h000
`define SWCH_ADDR_DIV        12'h004
`define SWCH_ADDR_STAT       12'h008
`define SWCH_ADDR_WPTR       12'h00C
`define SWCH_CTRL_RUN        0
`define SWCH_CTRL_DUAL       1
`define SWCH_CTRL_HOLD       2
`define SWCH_CTRL_SEG_LO     4
`define SWCH_CTRL_SEG_HI     6
`define SWCH_STAT_SWEEP      0
`define SWCH_STAT_EXTSEL     1
`define SWCH_STAT_READY      2
`define SWCH_STAT_TRACE      3
`endif

//--- swch_edge_sync.v
// two-stage synchroniser with falling edge detector
`timescale 1ns/1ps
module swch_edge_sync (
  pclk,
  presetn,
  async_in,
  sync_out,
  fall_pulse
);
  input  wire pclk;       // system clock
  input  wire presetn;    // async reset, active low
  input  wire async_in;   // pin from outside the domain
  output wire sync_out;   // synchronised level
  output wire fall_pulse; // one cycle per falling edge

  reg meta_ff;  // first stage, read only by sync_ff
  reg sync_ff;  // second stage
  reg prev_ff;  // delayed copy for edge detection

  // pins idle high, so reset to high to avoid a false edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign sync_out   = sync_ff;
  assign fall_pulse = prev_ff & ~sync_ff;
endmodule // swch_edge_sync

//--- swch_ext_src.sv
// external sample clock source with the two-wire handshake
`timescale 1ns/1ps
module swch_ext_src (
  input  wire logic ready_out, // handshake from the block
  output logic      ext_clk    // clock pin, idle high between bursts
);
  int err_cnt; // handshake waits that ran out
  initial begin
    ext_clk = 1'b1;
    err_cnt = 0;
  end
  // n falling edges at 200 ns, with or without waiting for ready
  task automatic send(input int n, input bit hs);
    int i;
    int w;
    // called on a clock edge: shift every pin change off the sampling edge
    #3;
    for (i = 0; i < n; i++) begin
      w = 0;
      // without the handshake ready is not looked at
      while (hs && ready_out !== 1'b1 && w < 100) begin
        #10;
        w++;
      end
      if (w == 100) err_cnt++;
      ext_clk = 1'b0;
      #100;
      ext_clk = 1'b1;
      #100;
    end
  endtask
endmodule // swch_ext_src

//--- swch_testbench.sv
// self-checking bench for the store write clock block
`timescale 1ns/1ps
`include "swch_defines.vh"
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", n, e, s); end end
module testbench;
  localparam int SMP = 16; // short store so the counter wraps often
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_clk, ext_sel_n_in;
  logic        gate_n_out, clk_out, ready_out, wr_strobe, wr_trace, er;
  logic [11:0] paddr, wr_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  seg_sel;
  int          bad_count, num_checks, scnt, tcnt, seed, d, n, n0, t0, e;
  swch_top #(.SAMPLES(SMP)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk), .ext_sel_n_in(ext_sel_n_in),
    .gate_n_out(gate_n_out), .clk_out(clk_out), .ready_out(ready_out),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_trace(wr_trace), .seg_sel(seg_sel));
  swch_ext_src i_src (.ready_out(ready_out), .ext_clk(ext_clk));
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // tally written samples and those of the second trace
  always @(posedge pclk) if (wr_strobe === 1'b1) begin
    scnt++;
    tcnt += (wr_trace === 1'b1);
  end
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin bad_count++; end_sim(); end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // snapshot the tallies away from the edge
  task automatic snap();
    @(negedge pclk);
    n0 = scnt; t0 = tcnt;
  endtask
  initial begin
    seed = 49576; bad_count = 0; num_checks = 0; scnt = 0; tcnt = 0;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; ext_sel_n_in = 1; presetn = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `SWCH_ADDR_DIV, 0); `CHK("div_rst", `SWCH_DIV_RST, rd[15:0])
    apb(0, 12'h010, 0); `CHK("unmapped", 2'b10, {er, |rd})
    `CHK("gate_idle", 1'b1, gate_n_out)
    // internal clock at a random rate, single then dual
    for (int k = 0; k < 2; k++) begin
      d = $unsigned($random(seed)) % 4;
      apb(1, `SWCH_ADDR_DIV, d);
      apb(1, `SWCH_ADDR_CTRL, 32'h51 | (k << 1));
      // let the old divider count run out before measuring the rate
      repeat (24) @(posedge pclk);
      snap();
      repeat (200) @(posedge pclk);
      @(negedge pclk);
      `CHK("gate_run", 1'b0, gate_n_out)
      `CHK("seg", 3'h5, seg_sel)
      e = scnt - n0 - 200 / (d + 1);
      `CHK("rate", 1'b1, e <= 1 && e >= -1)
      e = (tcnt - t0) * 2 - (scnt - n0);
      `CHK("trace", 1'b1, k ? (e <= 2 && e >= -2) : tcnt == t0)
    end
    apb(1, `SWCH_ADDR_CTRL, 0);
    apb(0, `SWCH_ADDR_WPTR, 0); `CHK("wptr", scnt % SMP, int'(rd[11:0]))
    // external clock: quiet pin, then handshaken edges
    ext_sel_n_in <= 1'b0;
    apb(1, `SWCH_ADDR_CTRL, 1);
    snap();
    repeat (50) @(posedge pclk);
    `CHK("quiet", n0, scnt)
    n = 1 + $unsigned($random(seed)) % 4;
    i_src.send(n, 1);
    repeat (10) @(posedge pclk);
    `CHK("ext_cnt", n0 + n, scnt)
    `CHK("hs_wait", 0, i_src.err_cnt)
    `CHK("ready", 1'b1, ready_out)
    // held store takes nothing, release resumes at the same place
    apb(1, `SWCH_ADDR_CTRL, 5); snap();
    i_src.send(2, 0);
    `CHK("hold", n0, scnt)
    `CHK("gate_hold", 1'b1, gate_n_out)
    apb(1, `SWCH_ADDR_CTRL, 1);
    i_src.send(2, 0);
    `CHK("resume", n0 + 2, scnt)
    apb(0, `SWCH_ADDR_WPTR, 0); `CHK("wptr2", scnt % SMP, int'(rd[11:0]))
    end_sim();
  end
endmodule // testbench

//--- swch_top.v
// store write clock selection, external clock handshake and write counter
`timescale 1ns/1ps
`include "swch_defines.vh"
module swch_top #(
  parameter SAMPLES = `SWCH_SWEEP_SAMPLES,
  parameter AW      = `SWCH_ADDR_W
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  ext_clk_in,
  ext_sel_n_in,
  gate_n_out,
  clk_out,
  ready_out,
  wr_strobe,
  wr_addr,
  wr_trace,
  seg_sel
);
  input  wire          pclk;         // 40 MHz system clock
  input  wire          presetn;      // async reset, active low
  input  wire          psel;         // apb select
  input  wire          penable;      // apb enable
  input  wire          pwrite;       // apb direction
  input  wire [11:0]   paddr;        // apb byte address
  input  wire [31:0]   pwdata;       // apb write data
  output reg  [31:0]   prdata;       // apb read data
  output wire          pready;       // apb ready, always one wait-free
  output wire          pslverr;      // apb error on unmapped address
  input  wire          ext_clk_in;   // external sample clock pin
  input  wire          ext_sel_n_in; // low selects external clock
  output wire          gate_n_out;   // low during write sweep
  output wire          clk_out;      // sample clock out
  output wire          ready_out;    // handshake ready to external source
  output reg           wr_strobe;    // one-cycle store write strobe
  output reg  [AW-1:0] wr_addr;      // store write address
  output reg           wr_trace;     // trace of current sample
  output wire [2:0]    seg_sel;      // display segment, read side only

  // control and state registers
  reg                  run_ff;     // enables sweeps
  reg                  dual_ff;    // dual channel / alternate locked
  reg                  hold_ff;    // display hold
  reg [2:0]            seg_ff;     // segment select
  reg [`SWCH_DIV_W-1:0] div_ff;    // internal rate divider reload
  reg [`SWCH_DIV_W-1:0] cnt_ff;    // internal divider counter
  reg                  clk_tog_ff; // toggling clock output
  reg                  ready_ff;   // handshake ready
  reg [1:0]            state_ff;   // sweep state
  reg [AW-1:0]         ptr_ff;     // write counter
  reg                  sel_ext_ff; // synchronised select

  localparam [1:0] ST_IDLE  = 2'b00; // no sweep running
  localparam [1:0] ST_SWEEP = 2'b01; // writing into the store

  wire ext_sync;  // synchronised external clock level
  wire ext_fall;  // external falling edge pulse
  wire sel_sync;  // synchronised select level
  wire int_tick;  // internal sample enable
  wire sample;    // chosen sample enable
  wire do_write;  // accepted sample

  // external clock pin through two flops then edge detect
  swch_edge_sync u_ext (
    .pclk       (pclk),
    .presetn    (presetn),
    .async_in   (ext_clk_in),
    .sync_out   (ext_sync),
    .fall_pulse (ext_fall)
  );

  // select pin through two flops; the edge output is unused
  swch_edge_sync u_sel (
    .pclk       (pclk),
    .presetn    (presetn),
    .async_in   (ext_sel_n_in),
    .sync_out   (sel_sync),
    .fall_pulse ()
  );

  // apb: single-cycle access, no wait states
  wire wr_en = psel & penable & pwrite;
  wire rd_hit = (paddr == `SWCH_ADDR_CTRL) | (paddr == `SWCH_ADDR_DIV) |
                (paddr == `SWCH_ADDR_STAT) | (paddr == `SWCH_ADDR_WPTR);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~rd_hit;

  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff  <= 1'b0;
      dual_ff <= 1'b0;
      hold_ff <= 1'b0;
      seg_ff  <= 3'h0;
      div_ff  <= `SWCH_DIV_RST;
    end else if (wr_en) begin
      case (paddr)
        `SWCH_ADDR_CTRL: begin
          run_ff  <= pwdata[`SWCH_CTRL_RUN];
          dual_ff <= pwdata[`SWCH_CTRL_DUAL];
          hold_ff <= pwdata[`SWCH_CTRL_HOLD];
          seg_ff  <= pwdata[`SWCH_CTRL_SEG_HI:`SWCH_CTRL_SEG_LO];
        end
        `SWCH_ADDR_DIV: begin
          div_ff <= pwdata[`SWCH_DIV_W-1:0];
        end
        default: begin
          run_ff <= run_ff;                      // read-only or unmapped: no effect
        end
      endcase
    end
  end

  // read mux; data registered so it changes only on access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `SWCH_ADDR_CTRL: prdata <= {25'h0, seg_ff, 1'b0, hold_ff, dual_ff, run_ff};
        `SWCH_ADDR_DIV:  prdata <= {16'h0, div_ff};
        `SWCH_ADDR_STAT: prdata <= {28'h0, wr_trace, ready_ff, sel_ext_ff,
                                    state_ff == ST_SWEEP};
        `SWCH_ADDR_WPTR: prdata <= {{(32-AW){1'b0}}, ptr_ff};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  // segment select only feeds the read side
  assign seg_sel = seg_ff;

  // internal sample divider, one-cycle enable; independent of seg_ff
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff     <= {`SWCH_DIV_W{1'b0}};
      clk_tog_ff <= 1'b0;
      sel_ext_ff <= 1'b0;
    end else begin
      sel_ext_ff <= ~sel_sync;
      if (cnt_ff == {`SWCH_DIV_W{1'b0}}) begin
        cnt_ff <= div_ff;
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
      if (sample) begin
        clk_tog_ff <= ~clk_tog_ff;
      end
    end
  end
  assign int_tick = (cnt_ff == {`SWCH_DIV_W{1'b0}});
  // external selected: only external edges sample, else internal ticks
  assign sample = sel_ext_ff ? ext_fall : int_tick;
  assign clk_out = clk_tog_ff;

  // handshake: ready low on edge, high again once the synchronised pin is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b1;
    end else if (sel_ext_ff & ext_fall) begin
      ready_ff <= 1'b0;
    end else if (~ready_ff & ext_sync) begin
      ready_ff <= 1'b1;
    end
  end
  assign ready_out = ready_ff;

  // sweep state and write counter; hold freezes position
  assign do_write = sample & run_ff & ~hold_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= ST_IDLE;
      ptr_ff    <= {AW{1'b0}};
      wr_strobe <= 1'b0;
      wr_addr   <= {AW{1'b0}};
      wr_trace  <= 1'b0;
    end else begin
      // strobe only with a counter step, so a sample in the idle cycle is dropped
      wr_strobe <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (run_ff & ~hold_ff) begin
            state_ff <= ST_SWEEP;                // resumes at ptr_ff
          end
        end
        ST_SWEEP: begin
          if (~run_ff | hold_ff) begin
            state_ff <= ST_IDLE;
          end else if (do_write) begin
            wr_strobe <= 1'b1;
            wr_addr  <= ptr_ff;
            // dual: alternate slots between traces
            wr_trace <= dual_ff & ptr_ff[0];
            if (ptr_ff == SAMPLES[AW-1:0] - 1'b1) begin
              ptr_ff <= {AW{1'b0}};
            end else begin
              ptr_ff <= ptr_ff + 1'b1;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
  assign gate_n_out = ~(state_ff == ST_SWEEP);
endmodule // swch_top

//--- swch_top_monitor.sv
// checker on the ports of the store write clock block
`timescale 1ns/1ps
module swch_mon #(
  parameter SAMPLES = 4000
) (
  input wire logic        pclk,         // system clock
  input wire logic        presetn,      // async reset, active low
  input wire logic        ext_clk_in,   // external clock pin
  input wire logic        ext_sel_n_in, // low selects external clock
  input wire logic        gate_n_out,   // low during a sweep
  input wire logic        clk_out,      // sample clock out
  input wire logic        ready_out,    // handshake ready
  input wire logic        wr_strobe,    // store write strobe
  input wire logic [11:0] wr_addr       // store write address
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a write only lands inside a sweep, never while held
  gate_strobe_a: assert property (wr_strobe |-> !gate_n_out) else $error("write outside sweep");
  // ready may drop only after the pin went low
  ready_fall_a: assert property ($fell(ready_out) |-> !$past(ext_clk_in)) else $error("ready fell");
  // ready comes back only once the pin is high again
  ready_rise_a: assert property ($rose(ready_out) |-> $past(ext_clk_in)) else $error("ready rose");
  // one strobe per external edge, never a run of two
  strobe_single_a: assert property (wr_strobe && !ext_sel_n_in |=> !wr_strobe) else $error("double");
  // the clock out follows every accepted sample
  clk_toggle_a: assert property (wr_strobe |-> clk_out != $past(clk_out)) else $error("clk out");
  // no write means the counter stands still
  addr_hold_a: assert property (!wr_strobe |-> $stable(wr_addr)) else $error("addr moved");
  // the counter wraps at the sweep length
  addr_range_a: assert property (wr_addr < SAMPLES) else $error("addr range");
  // external select with a quiet pin writes nothing
  idle_ext_a: assert property ((!ext_sel_n_in && ext_clk_in) [*6] |-> !wr_strobe) else $error("idle");
  // a selected falling edge pulls ready low within the resync bound
  sync_bound_a: assert property ((!ext_sel_n_in) [*4] ##0 $fell(ext_clk_in) |->
    ##[1:10] !ready_out) else $error("ready late");
endmodule // swch_mon
bind swch_top swch_mon #(.SAMPLES(SAMPLES)) i_mon (.pclk, .presetn, .ext_clk_in, .ext_sel_n_in,
  .gate_n_out, .clk_out, .ready_out, .wr_strobe, .wr_addr);
